/* src/adcs_top.sv */
// Converter sequencer with limit compare, register port, analog mux control.
// Assumes an analog core that returns a 12-bit result when asked at end of convert.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Each result is compared with upper and lower boundary pairs per enables.
// - A result beyond an enabled boundary sets the limit flag; interrupt if globally enabled.
// - Pin selected as analog input loses its other functions.
// - Pull-high resistor is removed on analog-input pins.
// - Analog selection overrides the pin direction setting.
// - Source 000 or 1xx picks external channel; 1010-1011 reserved, 111x floating.
// - Source 001 routes amplifier output; 010-011 ground the input.
// - Internal source selected disconnects every external channel.
// - Sample 4 converter clocks then convert 12, sixteen in total.
// - Trigger source bit picks software start bit or PWM interrupt.
// - Format bit sets placement of result across high and low bytes.
// - With software trigger, start high resets; conversion begins when start returns low.
// - Busy stays high during conversion, low at completion with valid result.
// - Power enable low stops all conversion activity.
// - Result is 12 bits, full scale fff.
// - Converter clock is system clock divided by two to the divider code.
// - Delay from PWM interrupt to start equals delay count system clocks; with delayed start and a count of 0 no conversion starts.
// - Completion sets the conversion flag; interrupt if enabled.
module adcs_top #(
	parameter int NPINS = 14
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire adcs_pkg::adcs_bus_t bus,
	output logic [7:0] rdata,
	input wire logic pwm_irq,
	input wire logic [11:0] core_result,
	output logic conv_done,
	output logic core_power,
	output logic core_sample,
	output adcs_pkg::adcs_mux_t mux,
	output logic [NPINS-1:0] pin_analog,
	output logic irq_conv,
	output logic irq_limit
);
	import adcs_pkg::*;

	initial begin
		if (NPINS < 1 || NPINS > 16) $error("NPINS out of range");
	end

	logic [7:0] ctrl_a_ff, ctrl_b_ff, trig_ff, delay_ff, irq_ff;
	logic [7:0] lo_l_ff, lo_h_ff, hi_l_ff, hi_h_ff;
	logic [15:0] pinsel_ff;
	logic [11:0] result_ff;
	adcs_state_t state_ff, nxt_state;
	logic [6:0] div_ff;
	logic [4:0] tick_ff;
	logic [7:0] dcnt_ff;
	logic start_q_ff, pwm_q_ff, busy_ff;

	function automatic logic wr_at(input adcs_bus_t b, input logic [3:0] a);
		return b.wr && b.addr == a;
	endfunction

	// Core clock cycles spanned by n converter ticks at a divider code
	function automatic logic [11:0] ticks_at(input int n, input logic [2:0] code);
		return 12'(n) << code;
	endfunction

	wire pwr = ctrl_a_ff[CA_PWR];
	wire [2:0] src = ctrl_b_ff[CB_SRC_LSB +: 3];
	wire [3:0] chan = ctrl_a_ff[3:0];
	// Divider terminal count: 2**code - 1
	wire [6:0] div_max = 7'((8'h01 << ctrl_b_ff[2:0]) - 8'h01);
	wire ck_tick = pwr && div_ff == div_max;
	wire sw_go = start_q_ff && !ctrl_a_ff[CA_START] && !trig_ff[TR_SRC];
	wire pwm_go = pwm_irq && !pwm_q_ff && trig_ff[TR_SRC];
	wire go_now = sw_go || (pwm_go && !trig_ff[TR_DLY]);
	wire go_dly = pwm_go && trig_ff[TR_DLY] && delay_ff != 8'h00;
	wire dly_end = state_ff == ADCS_DELAY && dcnt_ff == 8'h01;
	wire finish = state_ff == ADCS_CONV && ck_tick && tick_ff == 5'(TOTAL_TICKS - 1);
	wire [11:0] lo_b = {lo_h_ff[3:0], lo_l_ff};
	wire [11:0] hi_b = {hi_h_ff[3:0], hi_l_ff};
	wire below = trig_ff[TR_LCE] && core_result < lo_b;
	wire above = trig_ff[TR_UCE] && core_result > hi_b;
	wire lim_hit = finish && (below || above);
	wire ext_src = src == 3'b000 || src[2];
	wire ch_ok = chan <= 4'h9 || chan == 4'hc || chan == 4'hd;
	// Format 1: right aligned; 0: left aligned in high byte
	wire [7:0] res_h = ctrl_b_ff[CB_FMT] ? {4'h0, result_ff[11:8]} : result_ff[11:4];
	wire [7:0] res_l = ctrl_b_ff[CB_FMT] ? result_ff[7:0] : {result_ff[3:0], 4'h0};

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ADCS_IDLE: if (pwr) nxt_state = ADCS_ARMED;
			ADCS_ARMED: begin
				if (go_now) nxt_state = ADCS_CONV;
				else if (go_dly) nxt_state = ADCS_DELAY;
			end
			ADCS_DELAY: if (dly_end) nxt_state = ADCS_CONV;
			ADCS_CONV: if (finish) nxt_state = ADCS_ARMED;
			default: nxt_state = ADCS_IDLE;
		endcase
		// With the software trigger source selected, start high forces a restart of any conversion in flight
		if (ctrl_a_ff[CA_START] && !trig_ff[TR_SRC] && pwr) nxt_state = ADCS_ARMED;
		if (!pwr) nxt_state = ADCS_IDLE;
	end

	// Ticks count only inside the convert state, so the launch cycle is not a tick
	wire [4:0] nxt_tick = (nxt_state != ADCS_CONV) ? 5'h00 :
		(state_ff == ADCS_CONV && ck_tick) ? tick_ff + 5'h01 : tick_ff;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ADCS_IDLE;
			div_ff <= 7'h00;
			tick_ff <= 5'h00;
			dcnt_ff <= 8'h00;
			start_q_ff <= 1'b0;
			pwm_q_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_q_ff <= ctrl_a_ff[CA_START];
			pwm_q_ff <= pwm_irq;
			// Divider restarts on entry so the first tick is a full period
			div_ff <= (!pwr || ck_tick || state_ff != ADCS_CONV) ? 7'h00 : div_ff + 7'h01;
			tick_ff <= nxt_tick;
			if (state_ff == ADCS_ARMED) dcnt_ff <= delay_ff;
			else if (state_ff == ADCS_DELAY) dcnt_ff <= dcnt_ff - 8'h01;
			busy_ff <= nxt_state == ADCS_CONV || nxt_state == ADCS_DELAY;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_a_ff <= RST_BYTE;
			ctrl_b_ff <= RST_BYTE;
			trig_ff <= RST_BYTE;
			delay_ff <= RST_BYTE;
			lo_l_ff <= RST_BYTE;
			lo_h_ff <= RST_BYTE;
			hi_l_ff <= RST_BYTE;
			hi_h_ff <= RST_BYTE;
			pinsel_ff <= 16'h0000;
			result_ff <= 12'h000;
		end else begin
			if (wr_at(bus, OFS_CTRL_A)) ctrl_a_ff <= bus.wdata & 8'h3f;
			if (wr_at(bus, OFS_CTRL_B)) ctrl_b_ff <= bus.wdata & 8'h7f;
			if (wr_at(bus, OFS_TRIG)) trig_ff <= bus.wdata & 8'h0f;
			if (wr_at(bus, OFS_DELAY)) delay_ff <= bus.wdata;
			if (wr_at(bus, OFS_LO_L)) lo_l_ff <= bus.wdata;
			if (wr_at(bus, OFS_LO_H)) lo_h_ff <= bus.wdata & 8'h0f;
			if (wr_at(bus, OFS_HI_L)) hi_l_ff <= bus.wdata;
			if (wr_at(bus, OFS_HI_H)) hi_h_ff <= bus.wdata & 8'h0f;
			if (wr_at(bus, OFS_PINSEL)) pinsel_ff <= {pinsel_ff[7:0], bus.wdata};
			// Single 12-bit store keeps both byte views coherent
			if (finish) result_ff <= core_result & FULL_SCALE;
		end
	end

	// Sticky flags; hardware set wins over write-one clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= RST_BYTE;
			irq_conv <= 1'b0;
			irq_limit <= 1'b0;
		end else begin
			if (wr_at(bus, OFS_IRQ)) begin
				irq_ff[IR_CE] <= bus.wdata[IR_CE];
				irq_ff[IR_GE] <= bus.wdata[IR_GE];
			end
			irq_ff[IR_CF] <= finish | (irq_ff[IR_CF] & ~(wr_at(bus, OFS_IRQ) & bus.wdata[IR_CF]));
			irq_ff[IR_LF] <= lim_hit | (irq_ff[IR_LF] & ~(wr_at(bus, OFS_IRQ) & bus.wdata[IR_LF]));
			irq_conv <= irq_ff[IR_CF] & irq_ff[IR_CE] & irq_ff[IR_GE];
			irq_limit <= irq_ff[IR_LF] & irq_ff[IR_GE];
		end
	end

	logic [7:0] rd_mux;
	always_comb begin
		case (bus.addr)
			OFS_CTRL_A: rd_mux = {1'b0, busy_ff, ctrl_a_ff[5:0]};
			OFS_CTRL_B: rd_mux = ctrl_b_ff;
			OFS_TRIG: rd_mux = trig_ff;
			OFS_DELAY: rd_mux = delay_ff;
			OFS_RES_L: rd_mux = res_l;
			OFS_RES_H: rd_mux = res_h;
			OFS_LO_L: rd_mux = lo_l_ff;
			OFS_LO_H: rd_mux = lo_h_ff;
			OFS_HI_L: rd_mux = hi_l_ff;
			OFS_HI_H: rd_mux = hi_h_ff;
			OFS_IRQ: rd_mux = irq_ff;
			default: rd_mux = 8'h00;
		endcase
	end

	// Outputs all registered
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
			conv_done <= 1'b0;
			core_power <= 1'b0;
			core_sample <= 1'b0;
			mux <= '0;
			pin_analog <= '0;
		end else begin
			rdata <= bus.rd ? rd_mux : 8'h00;
			conv_done <= finish;
			core_power <= pwr;
			core_sample <= nxt_state == ADCS_CONV && nxt_tick < 5'(SAMPLE_TICKS);
			mux.ext_en <= pwr && ext_src && ch_ok;
			mux.ext_ch <= chan;
			mux.amp_sel <= pwr && src == 3'b001;
			mux.gnd_sel <= pwr && src[2:1] == 2'b01;
			// Analog pin removes pull-high, digital path and direction control
			pin_analog <= pinsel_ff[NPINS-1:0];
		end
	end

	busy_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		finish |=> !busy_ff && conv_done) else $error("busy not cleared at finish");
	limit_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		lim_hit |=> irq_ff[IR_LF]) else $error("limit flag missed");
	done_flag_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		finish |=> irq_ff[IR_CF]) else $error("done flag missed");
	power_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!pwr |=> !busy_ff && !core_sample) else $error("activity while off");
	ext_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!ext_src |=> !mux.ext_en) else $error("external left on");
	sw_start_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(sw_go && state_ff == ADCS_ARMED) |=> busy_ff) else $error("no start");
	result_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		finish |=> result_ff == $past(core_result)) else $error("result lost");
	sequence conv_launch_s;
		go_now && state_ff == ADCS_ARMED && ctrl_b_ff[2:0] == 3'h0;
	endsequence
	sequence conv_body_s;
		busy_ff ##15 (busy_ff && finish) ##1 !busy_ff;
	endsequence
	fast_conv_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		conv_launch_s |=> conv_body_s) else $error("conversion length wrong");

	// Run-length helpers; long phases are counted rather than unrolled
	logic [11:0] conv_run_ff, samp_run_ff;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_run_ff <= 12'h000;
			samp_run_ff <= 12'h000;
		end else begin
			conv_run_ff <= (state_ff == ADCS_CONV) ? conv_run_ff + 12'h001 : 12'h000;
			samp_run_ff <= core_sample ? samp_run_ff + 12'h001 : 12'h000;
		end
	end

	conv_span_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		finish |-> conv_run_ff == ticks_at(TOTAL_TICKS, ctrl_b_ff[2:0]) - 12'h001)
		else $error("convert span wrong");
	samp_span_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		($fell(core_sample) && pwr) |-> samp_run_ff == ticks_at(SAMPLE_TICKS, ctrl_b_ff[2:0]))
		else $error("sample span wrong");
	delay_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(go_dly && state_ff == ADCS_ARMED && pwr) |=> state_ff == ADCS_DELAY && dcnt_ff == $past(delay_ff))
		else $error("delay not loaded");
	delay_end_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(dly_end && pwr && !ctrl_a_ff[CA_START]) |=> state_ff == ADCS_CONV && busy_ff)
		else $error("delay did not start");
	conv_irq_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(irq_ff[IR_CF] && irq_ff[IR_CE] && irq_ff[IR_GE]) |=> irq_conv)
		else $error("conv irq missing");
	amp_route_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pwr && src == 3'b001) |=> mux.amp_sel && !mux.gnd_sel && !mux.ext_en)
		else $error("amplifier not routed");
	gnd_route_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(pwr && src[2:1] == 2'b01) |=> mux.gnd_sel && !mux.amp_sel && !mux.ext_en)
		else $error("ground not routed");
	bad_chan_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ext_src && !ch_ok) |=> !mux.ext_en) else $error("reserved channel connected");
	pin_sel_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		wr_at(bus, OFS_PINSEL) |=> ##1 pin_analog == $past(pinsel_ff[NPINS-1:0]))
		else $error("pin select lost");
	rd_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!bus.rd |=> rdata == 8'h00) else $error("read data not idle");
endmodule
`default_nettype wire

/* src/adcs_pkg.sv */
// Package for the converter sequencer: register map, fields, timing counts.
// Assumes a byte-wide register port driven synchronously to core_clk.
package adcs_pkg;
	localparam logic [3:0] OFS_CTRL_A = 4'h0;
	localparam logic [3:0] OFS_CTRL_B = 4'h1;
	localparam logic [3:0] OFS_TRIG = 4'h2;
	localparam logic [3:0] OFS_DELAY = 4'h3;
	localparam logic [3:0] OFS_RES_L = 4'h4;
	localparam logic [3:0] OFS_RES_H = 4'h5;
	localparam logic [3:0] OFS_LO_L = 4'h6;
	localparam logic [3:0] OFS_LO_H = 4'h7;
	localparam logic [3:0] OFS_HI_L = 4'h8;
	localparam logic [3:0] OFS_HI_H = 4'h9;
	localparam logic [3:0] OFS_IRQ = 4'ha;
	localparam logic [3:0] OFS_PINSEL = 4'hb;
	// Control A: [3:0] channel, 4 start, 5 power enable, 6 busy (ro)
	localparam int CA_START = 4;
	localparam int CA_PWR = 5;
	localparam int CA_BUSY = 6;
	// Control B: [2:0] clock divider, [5:3] input source, 6 result format
	localparam int CB_SRC_LSB = 3;
	localparam int CB_FMT = 6;
	// Trigger: 0 source select, 1 delayed start, 2 lower cmp en, 3 upper cmp en
	localparam int TR_SRC = 0;
	localparam int TR_DLY = 1;
	localparam int TR_LCE = 2;
	localparam int TR_UCE = 3;
	// Irq: 0 conv enable, 1 global enable, 2 conv flag, 3 limit flag (write 1 clears)
	localparam int IR_CE = 0;
	localparam int IR_GE = 1;
	localparam int IR_CF = 2;
	localparam int IR_LF = 3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int SAMPLE_TICKS = 4;
	localparam int CONVERT_TICKS = 12;
	localparam int TOTAL_TICKS = SAMPLE_TICKS + CONVERT_TICKS;
	localparam logic [11:0] FULL_SCALE = 12'hfff;
	typedef enum logic [1:0] {ADCS_IDLE, ADCS_ARMED, ADCS_DELAY, ADCS_CONV} adcs_state_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcs_bus_t;
	typedef struct packed {
		logic ext_en;
		logic [3:0] ext_ch;
		logic amp_sel;
		logic gnd_sel;
	} adcs_mux_t;
endpackage

/* sim/adc_sequencer_with_limit_compare_tb.sv */
// Self-checking bench for the converter sequencer: bus tasks, model queue.
// Assumes the register map and field positions of adcs_pkg.
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_with_limit_compare_tb;
	import adcs_pkg::*;
	logic core_clk, arst_n, pwm_irq, conv_done, core_power, core_sample, irq_conv, irq_limit;
	adcs_bus_t bus;
	adcs_mux_t mux;
	logic [7:0] rdata;
	logic [11:0] core_result;
	logic [13:0] pin_analog;
	int miscompares, checks, cyc, ns_cnt, q[$];
	logic [31:0] rs;
	adcs_top dut (.core_clk(core_clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.pwm_irq(pwm_irq), .core_result(core_result), .conv_done(conv_done),
		.core_power(core_power), .core_sample(core_sample), .mux(mux),
		.pin_analog(pin_analog), .irq_conv(irq_conv), .irq_limit(irq_limit));
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	// Free cycle count; sample phase length measured beside it
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (core_sample === 1'b1) ns_cnt <= ns_cnt + 1;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk) bus <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk) bus <= '0;
		#1 d = rdata;
	endtask
	// Waits for completion; a hang counts as a mismatch
	task automatic wait_done(output int t);
		int n;
		n = 0;
		while (conv_done !== 1'b1 && n < 5000) begin
			@(posedge core_clk) #1 n++;
		end
		t = cyc;
		if (n == 5000) begin
			miscompares++;
			finish_test();
		end
	endtask
	task automatic conv(input logic [2:0] dv, input logic pw);
		int t0, t, dl;
		logic [7:0] d;
		logic [11:0] r, lo, hi;
		logic lce, uce, fmt, ge, lim;
		rs = lfsr(rs);
		r = rs[11:0];
		lo = {1'b0, rs[22:12]};
		hi = lo | 12'h800;
		{ge, fmt, uce, lce} = rs[27:24];
		dl = 1 + rs[31:28];
		lim = (lce && r < lo) || (uce && r > hi);
		q.push_back(fmt ? {4'h0, r} : {r, 4'h0});
		core_result <= r;
		wr(OFS_LO_L, lo[7:0]);
		wr(OFS_LO_H, {4'h0, lo[11:8]});
		wr(OFS_HI_L, hi[7:0]);
		wr(OFS_HI_H, {4'h0, hi[11:8]});
		wr(OFS_CTRL_B, {1'b0, fmt, 3'b000, dv});
		wr(OFS_TRIG, {4'h0, uce, lce, pw, pw});
		wr(OFS_DELAY, pw ? 8'(dl) : 8'h00);
		wr(OFS_IRQ, {6'h00, ge, 1'b1});
		if (pw) begin
			wr(OFS_CTRL_A, 8'h20);
			@(posedge core_clk) pwm_irq <= 1'b1;
		end else begin
			wr(OFS_CTRL_A, 8'h30);
			repeat (30) @(posedge core_clk);
			chk("held_start", 16'h0, 16'(conv_done));
			wr(OFS_CTRL_A, 8'h20);
		end
		t0 = cyc;
		ns_cnt = 0;
		if (!pw) begin
			rd(OFS_CTRL_A, d);
			chk("busy", 16'h1, 16'(d[CA_BUSY]));
		end
		wait_done(t);
		t = t - t0 - (pw ? dl : 0) - (16 << dv);
		chk("conv_len", 16'h1, 16'(t >= 0 && t <= 6));
		chk("sample_len", 16'(4 << dv), 16'(ns_cnt));
		repeat (2) @(posedge core_clk);
		#1 chk("irqs", {14'h0, ge, ge & lim}, {14'h0, irq_conv, irq_limit});
		rd(OFS_RES_L, d);
		chk("res_l", 16'(q[0][7:0]), 16'(d));
		rd(OFS_RES_H, d);
		chk("res_h", 16'(q.pop_front() >> 8), 16'(d));
		rd(OFS_IRQ, d);
		chk("flags", {14'h0, lim, 1'b1}, 16'(d[3:2]));
		rd(OFS_CTRL_A, d);
		chk("busy_end", 16'h0, 16'(d[CA_BUSY]));
		wr(OFS_IRQ, 8'h0c);
		pwm_irq <= 1'b0;
	endtask
	initial begin
		logic [7:0] d;
		cyc = 0;
		arst_n = 0;
		bus = '0;
		pwm_irq = 0;
		core_result = '0;
		rs = 32'h1079700a;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 13; a++) begin
			rd(4'(a), d);
			chk("reset_val", 16'(RST_BYTE), 16'(d));
		end
		// Every source code and every channel code, idle converter
		for (int i = 0; i < 16; i++) begin
			wr(OFS_CTRL_A, 8'h20 | 8'((i * 5) % 16));
			wr(OFS_CTRL_B, 8'((i % 8) << CB_SRC_LSB));
			repeat (2) @(posedge core_clk);
			chk("amp", 16'(i % 8 == 1), 16'(mux.amp_sel));
			chk("gnd", 16'(i % 8 == 2 || i % 8 == 3), 16'(mux.gnd_sel));
			if (i % 8 inside {1, 2, 3}) chk("ext_off", 16'h0, 16'(mux.ext_en));
			else if ((i * 5) % 16 < 10 || (i * 5) % 16 inside {12, 13})
				chk("ext", 16'(16 + (i * 5) % 16), {11'h0, mux.ext_en, mux.ext_ch});
			else chk("ext_rsv", 16'h0, 16'(mux.ext_en));
		end
		rs = lfsr(rs);
		wr(OFS_PINSEL, rs[15:8]);
		wr(OFS_PINSEL, rs[7:0]);
		repeat (2) @(posedge core_clk);
		chk("pins", 16'(rs[13:0]), 16'(pin_analog));
		wr(OFS_CTRL_A, 8'h10);
		wr(OFS_CTRL_A, 8'h00);
		repeat (40) @(posedge core_clk);
		#1 chk("pwr_off", 16'h0, {14'h0, core_power, conv_done});
		for (int k = 0; k < 7; k++) conv(k == 6 ? 3'h7 : 3'(k % 3), k >= 3);
		finish_test();
	end
endmodule
`default_nettype wire
